// ---- slave_application_state_machine.sv ----
// Top of the slave application state machine with its register port
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Request register write starts a transition
// - Request bits 3:0 hold requested state
// - Request bit 4 one clears change flag
// - Report bits 3:0 show current state
// - Report bit 4 flags a refused request
// - Error code register holds last cause
// - Refused transition sets flag and code
// - Illegal state pairs refused with 0x0011
// - Init to bootstrap, bad mailbox: 0x0015
// - Init to preop, bad mailbox: 0x0016
// - Bad sync manager setup refused: 0x0017
// - Non-operational states drive substitute outputs
// - Substitute setup changes only in preop
module slave_application_state_machine
    import slave_sm_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output var  logic [DATA_W-1:0] reg_rdata,
    output var  logic              reg_rvalid,
    output var  logic              reg_miss,
    // Configuration status from the slave controller
    input  wire logic              mbx_cfg_valid,
    input  wire logic              sm_cfg_valid,
    // Substitute value configuration
    input  wire logic              cfg_wr,
    input  wire logic [7:0]        cfg_mode,
    input  wire logic [DOUT_W-1:0] cfg_pattern,
    output var  logic              cfg_refused,
    // Process data and outputs
    input  wire logic [DOUT_W-1:0] pdo_out_data,
    output var  logic [DOUT_W-1:0] digital_out,
    output var  logic [3:0]        slave_state,
    output var  logic              state_error
);

    check_if ci ();
    subst_if si ();

    slave_state_t state_q;
    logic         flag_q;
    logic [15:0]  code_q;
    logic [4:0]   request_q;
    logic [15:0]  rdata_q;
    logic         rvalid_q;
    logic         miss_q;
    logic         cfg_refused_q;

    logic         req_write;
    logic         ack_clear;
    logic         refused;
    logic [3:0]   req_state;

    // Register decode for the read path; writes match the request offset directly
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == OFF_STATE_REQUEST) || (a == OFF_STATE_REPORT) ||
               (a == OFF_STATE_ERROR_CODE);
    endfunction

    function automatic logic [DATA_W-1:0] read_word(
        input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] w;
        w = WORD_ZERO;
        if (a == OFF_STATE_REQUEST) begin
            w[FLAG_BIT:STATE_LSB] = request_q;
        end else if (a == OFF_STATE_REPORT) begin
            w[STATE_MSB:STATE_LSB] = state_q;
            w[FLAG_BIT]            = flag_q;
        end else if (a == OFF_STATE_ERROR_CODE) begin
            w = code_q;
        end
        return w;
    endfunction

    // Request decode
    always_comb begin
        req_write = reg_wr && (reg_addr == OFF_STATE_REQUEST);
        req_state = reg_wdata[STATE_MSB:STATE_LSB];
        ack_clear = req_write && reg_wdata[FLAG_BIT];
        refused   = req_write && !ci.ok;
    end

    // Transition judge
    always_comb begin
        ci.cur_state = state_q;
        ci.req_state = req_state;
        ci.mbx_ok    = mbx_cfg_valid;
        ci.sm_ok     = sm_cfg_valid;
    end

    state_transition_check u_check (
        .ci (ci.chk)
    );

    // Stored request; reserved bits are dropped and read back as zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            request_q <= {1'b0, ST_INIT};
        end else if (req_write) begin
            request_q <= reg_wdata[FLAG_BIT:STATE_LSB];
        end
    end

    // Slave state; a refused request leaves the state untouched
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_INIT;
        end else if (req_write && ci.ok) begin
            state_q <= slave_state_t'(req_state);
        end
    end

    // Change flag: a new refusal wins over an acknowledge in the
    // same write, so the master never loses an error report
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else if (refused) begin
            flag_q <= 1'b1;
        end else if (ack_clear) begin
            flag_q <= 1'b0;
        end
    end

    // Error code keeps the most recent cause until the next refusal
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            code_q <= ERR_NONE;
        end else if (refused) begin
            code_q <= ci.code;
        end
    end

    // Register reads answer one cycle later; unmapped ones read zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q  <= WORD_ZERO;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                rdata_q <= read_word(reg_addr);
            end
        end
    end

    // Access to an unmapped address, including writes to read-only
    // registers, is flagged for one cycle and otherwise ignored
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            miss_q <= 1'b0;
        end else begin
            miss_q <= (reg_rd && !is_mapped(reg_addr)) ||
                      (reg_wr && reg_addr != OFF_STATE_REQUEST);
        end
    end

    // Substitute configuration attempts outside preop are reported
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_refused_q <= 1'b0;
        end else begin
            cfg_refused_q <= cfg_wr && (state_q != ST_PREOP);
        end
    end

    // Output stage
    always_comb begin
        si.cfg_wr      = cfg_wr;
        si.cfg_mode    = cfg_mode;
        si.cfg_pattern = cfg_pattern;
        si.preop       = (state_q == ST_PREOP);
        si.operational = (state_q == ST_OP);
        si.pdo         = pdo_out_data;
    end

    output_substitute u_subst (
        .clk   (clk),
        .reset (reset),
        .si    (si.sub)
    );

    assign reg_rdata   = rdata_q;
    assign reg_rvalid  = rvalid_q;
    assign reg_miss    = miss_q;
    assign cfg_refused = cfg_refused_q;
    assign digital_out = si.dout;
    assign slave_state = state_q;
    assign state_error = flag_q;

endmodule

`default_nettype wire

// ---- slave_sm_pkg.sv ----
// Constants and types shared by the slave state machine design
package slave_sm_pkg;

    // Register port geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int DOUT_W = 16;

    // Register offsets
    localparam logic [15:0] OFF_STATE_REQUEST    = 16'h0120;
    localparam logic [15:0] OFF_STATE_REPORT     = 16'h0130;
    localparam logic [15:0] OFF_STATE_ERROR_CODE = 16'h0134;

    // Field positions in request and report registers
    localparam int STATE_LSB = 0;
    localparam int STATE_MSB = 3;
    localparam int FLAG_BIT  = 4;

    // Slave state encodings
    typedef enum logic [3:0] {
        ST_INIT   = 4'b0001,
        ST_PREOP  = 4'b0010,
        ST_BOOT   = 4'b0011,
        ST_SAFEOP = 4'b0100,
        ST_OP     = 4'b1000
    } slave_state_t;

    // Error codes
    localparam logic [15:0] ERR_NONE        = 16'h0000;
    localparam logic [15:0] ERR_BAD_CHANGE  = 16'h0011;
    localparam logic [15:0] ERR_UNKNOWN     = 16'h0012;
    localparam logic [15:0] ERR_MBX_BOOT    = 16'h0015;
    localparam logic [15:0] ERR_MBX_PREOP   = 16'h0016;
    localparam logic [15:0] ERR_SM_CONFIG   = 16'h0017;

    // Substitute value modes
    localparam logic [7:0] SAFE_ZERO    = 8'h00;
    localparam logic [7:0] SAFE_ONES    = 8'h01;
    localparam logic [7:0] SAFE_HOLD    = 8'h02;
    localparam logic [7:0] SAFE_PATTERN = 8'h03;

    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ONES = 16'hffff;

    function automatic logic is_known_state(input logic [3:0] s);
        return (s == ST_INIT) || (s == ST_PREOP) || (s == ST_BOOT) ||
               (s == ST_SAFEOP) || (s == ST_OP);
    endfunction

endpackage

// ---- slave_sm_if.sv ----
// Carriers between the top module and its two helpers
`timescale 1ns/1ps
`default_nettype none

interface check_if;
    logic [3:0]  cur_state;
    logic [3:0]  req_state;
    logic        mbx_ok;
    logic        sm_ok;
    logic        ok;
    logic [15:0] code;
    modport top (output cur_state, req_state, mbx_ok, sm_ok,
                 input ok, code);
    modport chk (input cur_state, req_state, mbx_ok, sm_ok,
                 output ok, code);
endinterface

interface subst_if;
    logic        cfg_wr;
    logic [7:0]  cfg_mode;
    logic [15:0] cfg_pattern;
    logic        preop;
    logic        operational;
    logic [15:0] pdo;
    logic [15:0] dout;
    modport top (output cfg_wr, cfg_mode, cfg_pattern, preop,
                 operational, pdo, input dout);
    modport sub (input cfg_wr, cfg_mode, cfg_pattern, preop,
                 operational, pdo, output dout);
endinterface

`default_nettype wire

// ---- state_transition_check.sv ----
// Judges a requested state change and names the refusal cause
`timescale 1ns/1ps
`default_nettype none

module state_transition_check
    import slave_sm_pkg::*;
(
    check_if.chk ci
);

    logic cur_i;
    logic cur_p;
    logic cur_s;
    logic cur_o;
    logic cur_b;
    logic bad_change;

    always_comb begin
        cur_i = (ci.cur_state == ST_INIT);
        cur_p = (ci.cur_state == ST_PREOP);
        cur_s = (ci.cur_state == ST_SAFEOP);
        cur_o = (ci.cur_state == ST_OP);
        cur_b = (ci.cur_state == ST_BOOT);
        // Bootstrap may only be left towards Init
        bad_change =
            (cur_i && (ci.req_state == ST_SAFEOP || ci.req_state == ST_OP))
            || (cur_p && (ci.req_state == ST_OP || ci.req_state == ST_BOOT))
            || ((cur_s || cur_o) && ci.req_state == ST_BOOT)
            || (cur_b && ci.req_state != ST_INIT);
    end

    always_comb begin
        ci.ok   = 1'b0;
        ci.code = ERR_NONE;
        if (!is_known_state(ci.req_state)) begin
            ci.code = ERR_UNKNOWN;
        end else if (ci.req_state == ci.cur_state) begin
            ci.ok = 1'b1;
        end else if (bad_change) begin
            ci.code = ERR_BAD_CHANGE;
        end else if (cur_i && ci.req_state == ST_BOOT && !ci.mbx_ok) begin
            ci.code = ERR_MBX_BOOT;
        end else if (cur_i && ci.req_state == ST_PREOP && !ci.mbx_ok) begin
            ci.code = ERR_MBX_PREOP;
        end else if (((cur_p && ci.req_state == ST_SAFEOP) ||
                      (cur_s && ci.req_state == ST_OP)) && !ci.sm_ok) begin
            ci.code = ERR_SM_CONFIG;
        end else begin
            ci.ok = 1'b1;
        end
    end

endmodule

`default_nettype wire

// ---- output_substitute.sv ----
// Drives the digital outputs, substituting values outside operational
`timescale 1ns/1ps
`default_nettype none

module output_substitute
    import slave_sm_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    subst_if.sub      si
);

    logic [7:0]  mode_q;
    logic [15:0] pattern_q;
    logic [15:0] dout_q;

    // Configuration is frozen outside pre-operational
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_q    <= SAFE_ZERO;
            pattern_q <= WORD_ZERO;
        end else if (si.cfg_wr && si.preop) begin
            mode_q    <= si.cfg_mode;
            pattern_q <= si.cfg_pattern;
        end
    end

    // Unknown mode codes fall back to all-zero, the safest level
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dout_q <= WORD_ZERO;
        end else if (si.operational) begin
            dout_q <= si.pdo;
        end else begin
            unique case (mode_q)
                SAFE_ONES:    dout_q <= WORD_ONES;
                SAFE_HOLD:    dout_q <= dout_q;
                SAFE_PATTERN: dout_q <= pattern_q;
                default:      dout_q <= WORD_ZERO;
            endcase
        end
    end

    assign si.dout = dout_q;

endmodule

`default_nettype wire

// ---- slave_state_checker.sv ----
// Port assertions for the slave application state machine
`timescale 1ns/1ps
`default_nettype none
module slave_state_checker
    import slave_sm_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              reset,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_miss,
    // Configuration and outputs
    input wire logic              mbx_cfg_valid,
    input wire logic              sm_cfg_valid,
    input wire logic              cfg_wr,
    input wire logic              cfg_refused,
    input wire logic [DOUT_W-1:0] pdo_out_data,
    input wire logic [DOUT_W-1:0] digital_out,
    input wire logic [3:0]        slave_state,
    input wire logic              state_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic       wq;
    logic [3:0] rq;
    assign wq = reg_wr && (reg_addr == OFF_STATE_REQUEST);
    assign rq = reg_wdata[3:0];
    property p_keep; !wq |=> $stable({slave_state, state_error}); endproperty
    a_keep: assert property (p_keep) else $error("state moved");
    property p_go;
        wq && slave_state == ST_INIT && rq == ST_PREOP && mbx_cfg_valid
        |=> slave_state == ST_PREOP;
    endproperty
    a_go: assert property (p_go) else $error("no change");
    property p_ack; wq && reg_wdata[4] && rq == slave_state |=> !state_error;
    endproperty
    a_ack: assert property (p_ack) else $error("flag kept");
    property p_bad;
        wq && slave_state == ST_INIT && (rq == ST_SAFEOP || rq == ST_OP)
        |=> slave_state == ST_INIT && state_error;
    endproperty
    a_bad: assert property (p_bad) else $error("bad change taken");
    property p_mbx;
        wq && slave_state == ST_INIT && rq == ST_PREOP && !mbx_cfg_valid
        |=> slave_state == ST_INIT && state_error;
    endproperty
    a_mbx: assert property (p_mbx) else $error("mailbox ignored");
    property p_sm;
        wq && slave_state == ST_PREOP && rq == ST_SAFEOP && !sm_cfg_valid
        |=> $stable(slave_state) && state_error;
    endproperty
    a_sm: assert property (p_sm) else $error("sync setup ignored");
    property p_out;
        slave_state == ST_OP ##1 slave_state == ST_OP
        |=> digital_out == $past(pdo_out_data);
    endproperty
    a_out: assert property (p_out) else $error("outputs wrong");
    property p_cfg; cfg_wr |=> cfg_refused == ($past(slave_state) != ST_PREOP);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config gate");
    property p_ro; reg_wr && reg_addr == OFF_STATE_REPORT |=> reg_miss;
    endproperty
    a_ro: assert property (p_ro) else $error("report written");
    property p_boot;
        wq && slave_state == ST_INIT && rq == ST_BOOT && !mbx_cfg_valid
        |=> slave_state == ST_INIT && state_error;
    endproperty
    a_boot: assert property (p_boot) else $error("boot taken");
    c_op: cover property (slave_state == ST_OP);
    c_err: cover property (state_error);
    c_ref: cover property (cfg_refused);
endmodule
bind slave_application_state_machine slave_state_checker chk (.*);
`default_nettype wire

// ---- fieldbus_master.sv ----
// Network master model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master
    import slave_sm_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Register port
    output var  logic [ADDR_W-1:0] reg_addr,
    output var  logic              reg_wr,
    output var  logic              reg_rd,
    output var  logic [DATA_W-1:0] reg_wdata,
    input  wire logic [DATA_W-1:0] reg_rdata,
    input  wire logic              reg_rvalid,
    input  wire logic              reg_miss
);
    initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
    // Idle lines show the inverse so stale values never look valid
    task automatic write(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    task automatic read(input logic [15:0] a, output logic [15:0] d,
                        output logic v, output logic m);
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        v        = reg_rvalid;
        m        = reg_miss;
        d        = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ---- slave_application_state_machine_bench.sv ----
// Self-checking bench for the slave application state machine
`timescale 1ns/1ps
`default_nettype none
module slave_application_state_machine_bench;
    import slave_sm_pkg::*;
    logic              clk, reset, reg_wr, reg_rd, reg_rvalid, reg_miss;
    logic              mbx_cfg_valid, sm_cfg_valid, cfg_wr, cfg_refused;
    logic              state_error;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [7:0]        cfg_mode;
    logic [DOUT_W-1:0] cfg_pattern, pdo_out_data, digital_out;
    logic [3:0]        slave_state;
    int                error_cnt, n_compared;
    slave_application_state_machine uut (.*);
    fieldbus_master m0 (.*);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s %h not %h", $time, what, seen,
                     exp);
        end
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic req(input logic [4:0] w, input logic [3:0] st,
                       input logic fl, input logic [15:0] code);
        logic [15:0] d;
        logic        v, m;
        m0.write(OFF_STATE_REQUEST, {11'h000, w});
        m0.read(OFF_STATE_REPORT, d, v, m);
        check({15'h0000, v}, 16'h0001, "rvalid");
        check(d, {11'h000, fl, st}, "report");
        if (fl) begin
            m0.read(OFF_STATE_ERROR_CODE, d, v, m);
            check(d, code, "code");
        end
    endtask
    task automatic cfg_try(input logic [7:0] md, input logic exp_ref,
                           input logic [15:0] exp_out);
        @(negedge clk);
        cfg_wr   = 1'b1;
        cfg_mode = md;
        @(negedge clk);
        cfg_wr = 1'b0;
        check({15'h0000, cfg_refused}, {15'h0000, exp_ref}, "refused");
        @(negedge clk);
        check(digital_out, exp_out, "substitute");
    endtask
    task automatic t_after_reset();
        logic [15:0] d;
        logic        v, m;
        m0.read(OFF_STATE_REPORT, d, v, m);
        check(d, 16'h0001, "reset report");
        m0.read(OFF_STATE_ERROR_CODE, d, v, m);
        check(d, ERR_NONE, "reset code");
        m0.read(16'h0200, d, v, m);
        check({15'h0000, m}, 16'h0001, "unmapped miss");
        m0.write(OFF_STATE_REPORT, 16'h0008);
        check({15'h0000, reg_miss}, 16'h0001, "read-only miss");
        check({12'h000, slave_state}, 16'h0001, "read-only state");
        $display("test after_reset done");
    endtask
    task automatic t_refusals();
        req(5'h04, ST_INIT, 1'b1, ERR_BAD_CHANGE);
        req(5'h08, ST_INIT, 1'b1, ERR_BAD_CHANGE);
        req(5'h05, ST_INIT, 1'b1, ERR_UNKNOWN);
        req(5'h03, ST_INIT, 1'b1, ERR_MBX_BOOT);
        req(5'h02, ST_INIT, 1'b1, ERR_MBX_PREOP);
        req(5'h01, ST_INIT, 1'b1, ERR_MBX_PREOP);
        req(5'h11, ST_INIT, 1'b0, ERR_NONE);
        $display("test refusals done");
    endtask
    task automatic t_walk();
        logic [15:0] d;
        logic        v, m;
        mbx_cfg_valid = 1'b1;
        req(5'h03, ST_BOOT, 1'b0, ERR_NONE);
        req(5'h02, ST_BOOT, 1'b1, ERR_BAD_CHANGE);
        req(5'h11, ST_INIT, 1'b0, ERR_NONE);
        req(5'h12, ST_PREOP, 1'b0, ERR_NONE);
        m0.read(OFF_STATE_REQUEST, d, v, m);
        check(d, 16'h0012, "request readback");
        req(5'h08, ST_PREOP, 1'b1, ERR_BAD_CHANGE);
        req(5'h03, ST_PREOP, 1'b1, ERR_BAD_CHANGE);
        req(5'h04, ST_PREOP, 1'b1, ERR_SM_CONFIG);
        $display("test walk done");
    endtask
    task automatic t_outputs();
        cfg_try(SAFE_PATTERN, 1'b0, 16'ha5c3);
        sm_cfg_valid = 1'b1;
        req(5'h14, ST_SAFEOP, 1'b0, ERR_NONE);
        cfg_try(SAFE_ONES, 1'b1, 16'ha5c3);
        sm_cfg_valid = 1'b0;
        req(5'h03, ST_SAFEOP, 1'b1, ERR_BAD_CHANGE);
        req(5'h08, ST_SAFEOP, 1'b1, ERR_SM_CONFIG);
        sm_cfg_valid = 1'b1;
        req(5'h18, ST_OP, 1'b0, ERR_NONE);
        check(digital_out, 16'h1234, "live outputs");
        req(5'h03, ST_OP, 1'b1, ERR_BAD_CHANGE);
        req(5'h14, ST_SAFEOP, 1'b0, ERR_NONE);
        check(digital_out, 16'ha5c3, "back to substitute");
        req(5'h12, ST_PREOP, 1'b0, ERR_NONE);
        cfg_try(SAFE_ONES, 1'b0, 16'hffff);
        cfg_try(SAFE_HOLD, 1'b0, 16'hffff);
        cfg_try(SAFE_ZERO, 1'b0, 16'h0000);
        $display("test outputs done");
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {reset, mbx_cfg_valid, sm_cfg_valid, cfg_wr} = 4'h8;
        cfg_mode     = SAFE_ZERO;
        cfg_pattern  = 16'ha5c3;
        pdo_out_data = 16'h1234;
        error_cnt    = 0;
        n_compared   = 0;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        t_after_reset();
        t_refusals();
        t_walk();
        t_outputs();
        results();
    end
    // Bounds the whole run so a stuck handshake cannot hang it
    initial begin
        #50000;
        error_cnt++;
        $display("unexpected at %0t: run timed out", $time);
        results();
    end
endmodule
`default_nettype wire
